/* nv_i2c_map.svh */
// Constants shared by both ends of the I2C nonvolatile-store link.
// Assumes it is included by bare name, before the package and modules.
`ifndef NV_I2C_MAP_SVH
`define NV_I2C_MAP_SVH
`define GCALL_ADDR 8'h00
`define CMD_SET_PTR 8'h10
`define CMD_WRITE 8'h12
`define CMD_READ 8'h14
`define PROT_LO 16'h0040
`define PROT_HI 16'h004e
`define CFG_A_LO 16'h0000
`define CFG_A_HI 16'h0010
`define CFG_B_LO 16'h0050
`define CFG_B_HI 16'h007e
`define MCLK_HZ 20000000
`define MCLK_NS 50
`define SCL_HZ 100000
`define NV_WRITE_NS 100000
`define NV_READ_NS 1000
`define BYTE_DONE 4'h8
`define ACK_SLOT 4'h8
`define OWN_ADDR 7'h22
`define READ_TRIES 4'h8
`endif

/* nv_i2c_pkg.sv */
// Types shared by the device end, the host end and the store core.
// Assumes nv_i2c_map.svh supplies every numeric constant.
package nv_i2c_pkg;
  typedef enum logic [1:0] {REQ_SET_PTR, REQ_WRITE, REQ_READ} req_kind_e;
  typedef enum logic [2:0] {D_IDLE, D_RX, D_ACK, D_TX, D_TXACK} dev_state_e;
  typedef enum logic [1:0] {PH_ADDR, PH_CMD, PH_DATA} dev_phase_e;
  typedef enum logic [2:0] {H_IDLE, H_START, H_TXB, H_RXB, H_STOP} host_state_e;

  typedef struct packed {
    dev_state_e st;
    dev_state_e after_ack;
    dev_phase_e ph;
    logic scl_q;
    logic sda_q;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] cmd;
    logic cmd_ok;
    logic data_ok;
    logic [1:0] dcnt;
    logic [7:0] ptr_hi;
    logic [15:0] ptr;
    logic [7:0] wdata;
    logic [7:0] txd;
    logic tx_valid;
    logic sda_oe_n;
    logic start_wr;
    logic start_rd;
  } dev_s;

  typedef struct packed {
    logic busy;
    logic wr;
    logic [15:0] timer;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rd_done;
    logic [7:0] sum;
    logic sum_ok;
  } store_s;

  typedef struct packed {
    host_state_e st;
    logic [1:0] q;
    logic [7:0] div;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [2:0] idx;
    req_kind_e kind;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic rdframe;
    logic nak;
    logic [3:0] tries;
    logic scl_oe_n;
    logic sda_oe_n;
    logic ready;
    logic done;
    logic ok;
    logic [7:0] rdata;
  } host_s;
endpackage

/* nv_i2c_link_if.sv */
// Open-drain SCL and SDA lines joining the host end and the device end.
// Assumes pull-ups: a line is high unless some end enables its driver.
`timescale 1ns/1ps
interface nv_i2c_link_if;
  logic host_scl_oe_n;
  logic host_sda_oe_n;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;

  // Wired-AND of the active-low enables gives the line levels.
  assign scl = host_scl_oe_n;
  assign sda = host_sda_oe_n & dev_sda_oe_n;

  modport host (output host_scl_oe_n, output host_sda_oe_n, input scl, input sda);
  modport dev (output dev_sda_oe_n, input scl, input sda);
endinterface

/* nv_store_core.sv */
// Nonvolatile store core: byte array, busy timing, area protection, checksum.
// Assumes one-cycle start pulses that arrive only while busy_out is low.
`timescale 1ns/1ps
`include "nv_i2c_map.svh"
module nv_store_core #(
  parameter int WORDS = 1024
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic start_wr_in,
  input wire logic start_rd_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic busy_out,
  output logic [7:0] rdata_out,
  output logic rd_done_out,
  output logic checksum_ok_out
);
  localparam int WR_CYC = (`NV_WRITE_NS + `MCLK_NS - 1) / `MCLK_NS;
  localparam int RD_CYC = (`NV_READ_NS + `MCLK_NS - 1) / `MCLK_NS;

  nv_i2c_pkg::store_s r;
  nv_i2c_pkg::store_s n;
  logic [7:0] mem [WORDS];
  logic in_range;
  logic commit;

  function automatic logic in_span(input logic [15:0] a, input logic [15:0] lo,
                                   input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // A write lands only inside the array and outside the reserved span.
  assign in_range = 32'(r.addr) < WORDS;
  assign commit = r.busy && r.wr && (r.timer == 16'h0000) && in_range
    && !in_span(r.addr, `PROT_LO, `PROT_HI); // see [RQ16] see [RQ14]

  // Sequencing of one store access at a time.
  always_comb begin
    n = r;
    n.rd_done = 1'b0;
    if (!r.busy && (start_wr_in || start_rd_in)) begin
      n.busy = 1'b1;
      n.wr = start_wr_in;
      n.addr = addr_in;
      n.wdata = wdata_in;
      n.timer = start_wr_in ? 16'(WR_CYC - 1) : 16'(RD_CYC - 1);
    end else if (r.busy && r.timer != 16'h0000) begin
      n.timer = r.timer - 16'h0001;
    end else if (r.busy) begin
      n.busy = 1'b0;
      n.rd_done = !r.wr;
      n.rdata = in_range ? mem[r.addr[$clog2(WORDS)-1:0]] : 8'h00;
    end
    // Configuration words feed a running check; any change upsets it.
    if (commit && (in_span(r.addr, `CFG_A_LO, `CFG_A_HI)
        || in_span(r.addr, `CFG_B_LO, `CFG_B_HI))) begin
      n.sum = r.sum ^ mem[r.addr[$clog2(WORDS)-1:0]] ^ r.wdata; // see [RQ15]
    end
    n.sum_ok = (n.sum == 8'h00);
  end

  // Control state register.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '0;
      r.sum_ok <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Array update; reset clears it so unwritten words and the check read as zero.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < WORDS; i++) begin
        mem[i] <= 8'h00;
      end
    end else if (commit) begin
      mem[r.addr[$clog2(WORDS)-1:0]] <= r.wdata;
    end
  end

  assign busy_out = r.busy;
  assign rdata_out = r.rdata;
  assign rd_done_out = r.rd_done;
  assign checksum_ok_out = r.sum_ok;
endmodule

/* nv_i2c_host.sv */
// Host end: I2C master that issues pointer-set, write and read transactions.
// Assumes one request at a time, taken while req_ready_out is high.
`timescale 1ns/1ps
`include "nv_i2c_map.svh"
module nv_i2c_host #(
  parameter int QUARTER = `MCLK_HZ / (4 * `SCL_HZ),
  parameter logic [6:0] DEV_ADDR = `OWN_ADDR,
  parameter logic [3:0] TRIES = `READ_TRIES
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic req_valid_in,
  input wire nv_i2c_pkg::req_kind_e req_kind_in,
  input wire logic [15:0] req_addr_in,
  input wire logic [7:0] req_wdata_in,
  output logic req_ready_out,
  output logic done_out,
  output logic ok_out,
  output logic [7:0] rdata_out,
  nv_i2c_link_if.host link
);
  nv_i2c_pkg::host_s r;
  nv_i2c_pkg::host_s n;
  logic tick;
  logic last;

  // Byte sent at each position of a frame.
  function automatic logic [7:0] frame_byte(input nv_i2c_pkg::host_s h, input logic [2:0] i);
    if (h.rdframe) return {DEV_ADDR, 1'b1}; // see [RQ13]
    unique case (i)
      3'h0: return `GCALL_ADDR;
      3'h1: return (h.kind == nv_i2c_pkg::REQ_SET_PTR) ? `CMD_SET_PTR :
                   (h.kind == nv_i2c_pkg::REQ_WRITE) ? `CMD_WRITE : `CMD_READ; // see [RQ1]
      3'h2: return (h.kind == nv_i2c_pkg::REQ_SET_PTR) ? h.addr[15:8] : h.wdata;
      default: return h.addr[7:0];
    endcase
  endfunction

  // Last byte index of the frame: four, three or two bytes, or one for the read-back frame.
  assign last = r.rdframe || (r.idx == ((r.kind == nv_i2c_pkg::REQ_SET_PTR) ? 3'h3 :
    (r.kind == nv_i2c_pkg::REQ_WRITE) ? 3'h2 : 3'h1)); // see [RQ2] see [RQ3] see [RQ4]
  assign tick = (r.div == 8'h00);

  // Quarter-bit sequencer; each bit spends four quarter ticks.
  always_comb begin
    n = r;
    n.done = 1'b0;
    n.div = tick ? 8'(QUARTER - 1) : r.div - 8'h01;
    if (r.st == nv_i2c_pkg::H_IDLE) begin
      n.div = 8'(QUARTER - 1);
      if (req_valid_in) begin
        n.st = nv_i2c_pkg::H_START;
        n.ready = 1'b0;
        n.kind = req_kind_in;
        n.addr = req_addr_in;
        n.wdata = req_wdata_in;
        n.rdframe = 1'b0;
        n.q = 2'h0;
      end
    end else if (tick) begin
      n.q = r.q + 2'h1;
      unique case (r.st)
        nv_i2c_pkg::H_START: begin
          if (r.q == 2'h2) n.sda_oe_n = 1'b0;
          if (r.q == 2'h3) begin
            n.scl_oe_n = 1'b0;
            n.st = nv_i2c_pkg::H_TXB;
            n.idx = 3'h0;
            n.bitn = 4'h0;
            n.nak = 1'b0;
            n.sh = frame_byte(r, 3'h0);
          end
        end
        nv_i2c_pkg::H_TXB, nv_i2c_pkg::H_RXB: begin
          if (r.q == 2'h0) n.sda_oe_n = (r.st == nv_i2c_pkg::H_RXB) || (r.bitn == `ACK_SLOT)
            || r.sh[7];
          if (r.q == 2'h1) n.scl_oe_n = 1'b1;
          if (r.q == 2'h2 && r.bitn == `ACK_SLOT && r.st == nv_i2c_pkg::H_TXB) n.nak = link.sda;
          if (r.q == 2'h2 && r.bitn != `ACK_SLOT && r.st == nv_i2c_pkg::H_RXB) begin
            n.sh = {r.sh[6:0], link.sda};
          end
          if (r.q == 2'h3) begin
            n.scl_oe_n = 1'b0;
            n.bitn = r.bitn + 4'h1;
            if (r.st == nv_i2c_pkg::H_TXB && r.bitn != `ACK_SLOT) n.sh = {r.sh[6:0], 1'b0};
            if (r.bitn == `ACK_SLOT) begin
              n.bitn = 4'h0;
              if (r.st == nv_i2c_pkg::H_RXB) begin
                n.rdata = r.sh;
                n.st = nv_i2c_pkg::H_STOP;
              end else if (r.nak) begin
                n.st = nv_i2c_pkg::H_STOP; // see [RQ13]
              end else if (r.rdframe) begin
                n.st = nv_i2c_pkg::H_RXB;
              end else if (last) begin
                n.st = nv_i2c_pkg::H_STOP;
              end else begin
                n.idx = r.idx + 3'h1;
                n.sh = frame_byte(r, r.idx + 3'h1);
              end
            end
          end
        end
        nv_i2c_pkg::H_STOP: begin
          if (r.q == 2'h0) n.sda_oe_n = 1'b0;
          if (r.q == 2'h1) n.scl_oe_n = 1'b1;
          if (r.q == 2'h2) n.sda_oe_n = 1'b1;
          if (r.q == 2'h3) begin
            if (r.kind == nv_i2c_pkg::REQ_READ && !r.rdframe && !r.nak) begin
              n.rdframe = 1'b1;
              n.tries = TRIES;
              n.st = nv_i2c_pkg::H_START;
            end else if (r.rdframe && r.nak && r.tries != 4'h0) begin
              n.tries = r.tries - 4'h1; // see [RQ13]
              n.st = nv_i2c_pkg::H_START;
            end else begin
              n.st = nv_i2c_pkg::H_IDLE;
              n.done = 1'b1;
              n.ok = !r.nak;
              n.ready = 1'b1;
            end
          end
        end
        nv_i2c_pkg::H_IDLE: ;
      endcase
    end
  end

  // State register; lines released and ready after reset.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '0;
      r.scl_oe_n <= 1'b1;
      r.sda_oe_n <= 1'b1;
      r.ready <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign req_ready_out = r.ready;
  assign done_out = r.done;
  assign ok_out = r.ok;
  assign rdata_out = r.rdata;
  assign link.host_scl_oe_n = r.scl_oe_n;
  assign link.host_sda_oe_n = r.sda_oe_n;
endmodule

/* nv_i2c_device.sv */
// Device end: I2C slave command handler for the nonvolatile store.
// Assumes SCL and SDA are synchronous to mclk_in and slow beside it.
`timescale 1ns/1ps
`include "nv_i2c_map.svh"
// Contract
// [RQ1] Commands: set pointer, write byte, read byte.
// [RQ2] Pointer set carries two address bytes.
// [RQ3] Write carries exactly one data byte.
// [RQ4] Read returns one byte from pointer.
// [RQ5] Pointer-set command ACK only when store idle.
// [RQ6] Busy store: NAK command and data phases.
// [RQ7] Pointer loads only while store is idle.
// [RQ8] Master sets pointer before write or read.
// [RQ9] Programming starts after command plus data byte.
// [RQ10] Write needs both command and data ACK.
// [RQ11] Master may verify a write by reading.
// [RQ12] Read command starts store read; ACK shows service.
// [RQ13] Master retries read after a NAK.
// [RQ14] User areas are freely readable and writable.
// [RQ15] Configuration words are covered by checksum.
// [RQ16] Reserved configuration span ignores all writes.
// [RQ17] Fetched byte goes out on next master read.
module nv_i2c_device #(
  parameter int WORDS = 1024,
  parameter logic [6:0] DEV_ADDR = `OWN_ADDR
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  output logic [15:0] ptr_out,
  output logic busy_out,
  output logic checksum_ok_out,
  nv_i2c_link_if.dev link
);
  nv_i2c_pkg::dev_s r;
  nv_i2c_pkg::dev_s n;
  logic ack;
  logic busy;
  logic rd_done;
  logic [7:0] rdata;
  logic rise;
  logic fall;
  logic start_cond;
  logic stop_cond;

  // True for the three known command codes.
  function automatic logic known_cmd(input logic [7:0] c);
    return (c == `CMD_SET_PTR) || (c == `CMD_WRITE) || (c == `CMD_READ); // see [RQ1]
  endfunction

  // Number of data bytes a command takes after its code.
  function automatic logic [1:0] data_need(input logic [7:0] c);
    if (c == `CMD_SET_PTR) return 2'h2; // see [RQ2]
    if (c == `CMD_WRITE) return 2'h1; // see [RQ3]
    return 2'h0;
  endfunction

  nv_store_core #(
    .WORDS(WORDS)
  ) u_store (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .start_wr_in(r.start_wr),
    .start_rd_in(r.start_rd),
    .addr_in(r.ptr),
    .wdata_in(r.wdata),
    .busy_out(busy),
    .rdata_out(rdata),
    .rd_done_out(rd_done),
    .checksum_ok_out(checksum_ok_out)
  );

  // Line events seen against the previous samples.
  assign rise = !r.scl_q && link.scl;
  assign fall = r.scl_q && !link.scl;
  assign start_cond = r.scl_q && link.scl && r.sda_q && !link.sda;
  assign stop_cond = r.scl_q && link.scl && !r.sda_q && link.sda;

  // Byte reception, acknowledge decisions and the transmit shifter.
  always_comb begin
    n = r;
    ack = 1'b0;
    n.scl_q = link.scl;
    n.sda_q = link.sda;
    n.start_wr = 1'b0;
    n.start_rd = 1'b0;
    // A finished store read parks its byte for the next master read.
    if (rd_done) begin
      n.txd = rdata;
      n.tx_valid = 1'b1; // see [RQ17]
    end
    if (start_cond) begin
      n.st = nv_i2c_pkg::D_RX;
      n.ph = nv_i2c_pkg::PH_ADDR;
      n.cnt = 4'h0;
      n.sda_oe_n = 1'b1;
    end else if (stop_cond) begin
      n.st = nv_i2c_pkg::D_IDLE;
      n.sda_oe_n = 1'b1;
    end else if (rise) begin
      if (r.st == nv_i2c_pkg::D_RX && r.cnt != `BYTE_DONE) begin
        n.sh = {r.sh[6:0], link.sda};
        n.cnt = r.cnt + 4'h1;
      end
    end else if (fall) begin
      unique case (r.st)
        nv_i2c_pkg::D_RX: begin
          if (r.cnt == `BYTE_DONE) begin
            n.st = nv_i2c_pkg::D_ACK;
            n.after_ack = nv_i2c_pkg::D_RX;
            unique case (r.ph)
              nv_i2c_pkg::PH_ADDR: begin
                if (r.sh == `GCALL_ADDR) begin
                  ack = 1'b1;
                  n.ph = nv_i2c_pkg::PH_CMD;
                end else if (r.sh == {DEV_ADDR, 1'b1}) begin
                  // Read-back frame: ACK only once the fetched byte is held.
                  ack = r.tx_valid && !busy; // see [RQ17] see [RQ13]
                  n.after_ack = ack ? nv_i2c_pkg::D_TX : nv_i2c_pkg::D_IDLE;
                end else begin
                  n.after_ack = nv_i2c_pkg::D_IDLE;
                end
              end
              nv_i2c_pkg::PH_CMD: begin
                // The command slot reports whether the store is free.
                ack = !busy && known_cmd(r.sh); // see [RQ5] see [RQ6] see [RQ12]
                n.cmd = r.sh;
                n.cmd_ok = ack;
                n.data_ok = 1'b1;
                n.dcnt = 2'h0;
                n.ph = nv_i2c_pkg::PH_DATA;
                if (ack && r.sh == `CMD_READ) begin
                  n.start_rd = 1'b1; // see [RQ12] see [RQ4]
                  n.tx_valid = 1'b0;
                end
              end
              nv_i2c_pkg::PH_DATA: begin
                // Data slots NAK on a busy store, a refused command or excess bytes.
                ack = r.cmd_ok && r.data_ok && !busy
                  && (r.dcnt < data_need(r.cmd)); // see [RQ6] see [RQ10]
                n.data_ok = ack;
                if (r.dcnt != 2'h3) n.dcnt = r.dcnt + 2'h1;
                if (ack && r.cmd == `CMD_SET_PTR && r.dcnt == 2'h0) n.ptr_hi = r.sh;
                if (ack && r.cmd == `CMD_SET_PTR && r.dcnt == 2'h1) begin
                  n.ptr = {r.ptr_hi, r.sh}; // see [RQ7] see [RQ2]
                end
                if (ack && r.cmd == `CMD_WRITE) begin
                  n.start_wr = 1'b1; // see [RQ9] see [RQ10] see [RQ3]
                  n.wdata = r.sh;
                end
              end
              default: ;
            endcase
            n.sda_oe_n = !ack;
          end
        end
        nv_i2c_pkg::D_ACK: begin
          n.sda_oe_n = 1'b1;
          n.cnt = 4'h0;
          n.st = r.after_ack;
          if (r.after_ack == nv_i2c_pkg::D_TX) begin
            n.sda_oe_n = r.txd[7]; // see [RQ17]
            n.sh = {r.txd[6:0], 1'b0};
            n.cnt = 4'h1;
          end
        end
        nv_i2c_pkg::D_TX: begin
          if (r.cnt == `BYTE_DONE) begin
            n.sda_oe_n = 1'b1;
            n.st = nv_i2c_pkg::D_TXACK;
            n.tx_valid = 1'b0;
          end else begin
            n.sda_oe_n = r.sh[7];
            n.sh = {r.sh[6:0], 1'b0};
            n.cnt = r.cnt + 4'h1;
          end
        end
        nv_i2c_pkg::D_TXACK: n.st = nv_i2c_pkg::D_IDLE;
        nv_i2c_pkg::D_IDLE: ;
      endcase
    end
  end

  // State register; SDA released and lines taken as idle-high after reset.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '0;
      r.scl_q <= 1'b1;
      r.sda_q <= 1'b1;
      r.sda_oe_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign ptr_out = r.ptr;
  assign busy_out = busy;
  assign link.dev_sda_oe_n = r.sda_oe_n;
endmodule

/* nv_i2c_link_monitor.sv */
// Concurrent checks on the link between the host end and the device end.
// Assumes it sits beside the link interface and shares its single clock.
`timescale 1ns/1ps
module nv_i2c_link_monitor (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic host_sda_oe_n_in,
  input wire logic dev_sda_oe_n_in,
  input wire logic scl_in,
  input wire logic [15:0] ptr_in,
  input wire logic busy_in
);
  // Longest busy span accepted; a write keeps the store busy for 2000 cycles.
  localparam logic [11:0] BUSY_LIMIT = 12'h834;
  logic [11:0] busy_run;

  // Counts the cycles of the current busy span, stopping at the limit.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_run <= 12'h000;
    end else if (!busy_in) begin
      busy_run <= 12'h000;
    end else if (busy_run != BUSY_LIMIT) begin
      busy_run <= busy_run + 12'h001;
    end
  end

  // Every check uses mclk_in and is off during reset.
  default clocking mon_cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  // The device pulls SDA for an acknowledge within about one bit time.
  sequence dev_acks;
    ##[0:30] !dev_sda_oe_n_in;
  endsequence

  // The device releases SDA soon and keeps it released for a while.
  sequence dev_lets_go;
    ##[1:40] dev_sda_oe_n_in [*8];
  endsequence

  a_ptr_when_idle: assert property ($changed(ptr_in) |-> !$past(busy_in))
    else $error("pointer moved while store busy");
  a_ptr_on_ack: assert property ($changed(ptr_in) |-> dev_acks)
    else $error("pointer moved without an acknowledge");
  a_busy_after_ack: assert property ($rose(busy_in) |-> dev_acks)
    else $error("store started without an acknowledge");
  a_busy_min_span: assert property ($rose(busy_in) |-> busy_in [*8])
    else $error("store busy pulse too short");
  a_busy_ends: assert property (busy_in |-> busy_run != BUSY_LIMIT)
    else $error("store stayed busy too long");
  a_ack_then_free: assert property ($rose(busy_in) |-> dev_lets_go)
    else $error("device kept SDA after starting the store");
  a_sda_scl_low: assert property ($changed(dev_sda_oe_n_in) |-> !scl_in)
    else $error("device changed SDA while SCL high");
  a_sda_release: assert property ($fell(dev_sda_oe_n_in) |-> ##[1:400] dev_sda_oe_n_in)
    else $error("device held SDA too long");
  a_start_free: assert property ($fell(host_sda_oe_n_in) && scl_in |-> dev_sda_oe_n_in)
    else $error("device drove SDA during a start");
endmodule

/* i2c_nvm_program_access_test.sv */
// Testbench joining the host end and the device end over one link.
// Assumes the package, interface, both ends and the monitor compile first.
`timescale 1ns/1ps
module i2c_nvm_program_access_test;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic req_valid = 1'b0;
  nv_i2c_pkg::req_kind_e req_kind = nv_i2c_pkg::REQ_SET_PTR;
  logic [15:0] req_addr = 16'h0000;
  logic [7:0] req_wdata = 8'h00;
  logic req_ready, done, ok, busy, sum_ok, last_ok;
  logic [7:0] rdata, last_rdata;
  logic [15:0] ptr;
  int fail_count = 0;
  int check_count = 0;

  nv_i2c_link_if link();
  nv_i2c_host #(.QUARTER(5)) i_nv_i2c_host (.mclk_in(mclk_in), .rst_in(rst_in),
    .req_valid_in(req_valid), .req_kind_in(req_kind), .req_addr_in(req_addr),
    .req_wdata_in(req_wdata), .req_ready_out(req_ready), .done_out(done), .ok_out(ok),
    .rdata_out(rdata), .link(link));
  nv_i2c_device i_nv_i2c_device (.mclk_in(mclk_in), .rst_in(rst_in), .ptr_out(ptr),
    .busy_out(busy), .checksum_ok_out(sum_ok), .link(link));
  nv_i2c_link_monitor i_nv_i2c_link_monitor (.mclk_in(mclk_in), .rst_in(rst_in),
    .host_sda_oe_n_in(link.host_sda_oe_n), .dev_sda_oe_n_in(link.dev_sda_oe_n),
    .scl_in(link.scl), .ptr_in(ptr), .busy_in(busy));

  // Clock of 50 ns period.
  initial begin
    forever #25 mclk_in = ~mclk_in;
  end

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Counts a wait that ran out and closes the run.
  task automatic timeout(input string what);
    fail_count++;
    $display("mismatch %s expected done seen timeout", what);
    end_sim();
  endtask

  // Compares one value and reports a difference.
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Issues one host request at a falling edge and waits for its done pulse.
  task automatic run_req(input nv_i2c_pkg::req_kind_e kind, input logic [15:0] addr,
                         input logic [7:0] wdata);
    int n;
    req_kind = kind;
    req_addr = addr;
    req_wdata = wdata;
    req_valid = 1'b1;
    n = 0;
    while (req_ready !== 1'b1) begin
      @(negedge mclk_in);
      n++;
      if (n > 20000) timeout("request ready");
    end
    @(negedge mclk_in);
    req_valid = 1'b0;
    n = 0;
    while (done !== 1'b1) begin
      @(negedge mclk_in);
      n++;
      if (n > 20000) timeout("request done");
    end
    last_ok = ok;
    last_rdata = rdata;
    @(negedge mclk_in);
  endtask

  // Waits until the store has finished its current access.
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0) begin
      @(negedge mclk_in);
      n++;
      if (n > 3000) timeout("store idle");
    end
  endtask

  // Writes and reads back one word in two of the user areas: 0x0012 and the top word 0x03ff.
  task automatic s_user_areas();
    logic [15:0] a [2] = '{16'h0012, 16'h03ff};
    logic [7:0] d;
    foreach (a[i]) begin
      d = a[i][7:0] ^ 8'h5a;
      run_req(nv_i2c_pkg::REQ_SET_PTR, a[i], 8'h00);
      chk("set ack", 16'h0001, {15'h0000, last_ok});
      chk("pointer", a[i], ptr);
      run_req(nv_i2c_pkg::REQ_WRITE, 16'h0000, d);
      chk("write ack", 16'h0001, {15'h0000, last_ok});
      wait_idle();
      run_req(nv_i2c_pkg::REQ_SET_PTR, a[i], 8'h00);
      run_req(nv_i2c_pkg::REQ_READ, 16'h0000, 8'h00);
      chk("read ack", 16'h0001, {15'h0000, last_ok});
      chk("read byte", {8'h00, d}, {8'h00, last_rdata});
    end
    chk("checksum", 16'h0001, {15'h0000, sum_ok});
  endtask

  // Requests made while a write programs the store are all refused.
  task automatic s_busy_refusal();
    run_req(nv_i2c_pkg::REQ_SET_PTR, 16'h0020, 8'h00);
    run_req(nv_i2c_pkg::REQ_WRITE, 16'h0000, 8'h3c);
    chk("busy after write", 16'h0001, {15'h0000, busy});
    run_req(nv_i2c_pkg::REQ_SET_PTR, 16'h0030, 8'h00);
    chk("busy set ack", 16'h0000, {15'h0000, last_ok});
    chk("held pointer", 16'h0020, ptr);
    run_req(nv_i2c_pkg::REQ_WRITE, 16'h0000, 8'h77);
    chk("busy write ack", 16'h0000, {15'h0000, last_ok});
    run_req(nv_i2c_pkg::REQ_READ, 16'h0000, 8'h00);
    chk("busy read ack", 16'h0000, {15'h0000, last_ok});
    wait_idle();
    run_req(nv_i2c_pkg::REQ_SET_PTR, 16'h0020, 8'h00);
    run_req(nv_i2c_pkg::REQ_READ, 16'h0000, 8'h00);
    chk("kept byte", 16'h003c, {8'h00, last_rdata});
  endtask

  // A write to the reserved span leaves its cleared content in place.
  task automatic s_protected();
    run_req(nv_i2c_pkg::REQ_SET_PTR, 16'h0045, 8'h00);
    run_req(nv_i2c_pkg::REQ_WRITE, 16'h0000, 8'h5a);
    wait_idle();
    run_req(nv_i2c_pkg::REQ_SET_PTR, 16'h0045, 8'h00);
    run_req(nv_i2c_pkg::REQ_READ, 16'h0000, 8'h00);
    chk("reserved byte", 16'h0000, {8'h00, last_rdata});
    chk("checksum", 16'h0001, {15'h0000, sum_ok});
  endtask

  // A configuration word write lands and disturbs the checksum.
  task automatic s_config();
    run_req(nv_i2c_pkg::REQ_SET_PTR, 16'h0010, 8'h00);
    run_req(nv_i2c_pkg::REQ_WRITE, 16'h0000, 8'h11);
    wait_idle();
    chk("checksum", 16'h0000, {15'h0000, sum_ok});
    run_req(nv_i2c_pkg::REQ_SET_PTR, 16'h0010, 8'h00);
    run_req(nv_i2c_pkg::REQ_READ, 16'h0000, 8'h00);
    chk("config byte", 16'h0011, {8'h00, last_rdata});
  endtask

  // Main sequence: reset, then each scenario in turn.
  initial begin
    repeat (6) @(negedge mclk_in);
    rst_in = 1'b0;
    @(negedge mclk_in);
    chk("reset pointer", 16'h0000, ptr);
    chk("reset checksum", 16'h0001, {15'h0000, sum_ok});
    s_user_areas();
    s_busy_refusal();
    s_protected();
    s_config();
    end_sim();
  end
endmodule
